// ===== logic/efi_pkg.sv
// register map, field layout and ecc constants of the ecc fault injection block
package efi_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CFG_LOW   = 8'h00;
    localparam logic [7:0] OFF_CFG_HIGH  = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW  = 8'h08;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h0c;
    localparam logic [7:0] OFF_STAT_LOW  = 8'h10;
    localparam logic [7:0] OFF_STAT_HIGH = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
    localparam int ENABLE_BIT   = 0;
    localparam int PTR_A_LSB    = 0;
    localparam int PTR_B_LSB    = 8;
    localparam int PTR_W        = 8;
    localparam int CALC_LSB     = 8;
    localparam int STORED_LSB   = 0;
    localparam int DED_FLAG_BIT = 9;
    localparam int DED_PAR_BIT  = 8;
    localparam int SYND_LSB     = 0;
    localparam int DATA_W       = 128;
    localparam int SEC_W        = 8;
    localparam int CW_W         = 137;
    localparam int DED_POS      = 136;
    localparam logic [7:0] PTR_LIMIT = 8'h89;
    localparam int IRQ_MATCH_BIT  = 0;
    localparam int IRQ_SINGLE_BIT = 1;
    localparam int IRQ_DOUBLE_BIT = 2;
    localparam int IRQ_W          = 3;
    localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

// ===== logic/efi_bit_flip.sv
// inverts up to two pointed bits of a codeword
`timescale 1ns/10ps
`default_nettype none
module efi_bit_flip
(
    input  wire logic [efi_pkg::CW_W-1:0]  cw_in,
    input  wire logic                      flip_en,
    input  wire logic [efi_pkg::PTR_W-1:0] ptr_a,
    input  wire logic [efi_pkg::PTR_W-1:0] ptr_b,
    output logic      [efi_pkg::CW_W-1:0]  cw_out
);
    function automatic logic [efi_pkg::CW_W-1:0] flip_mask(input logic [7:0] ptr);
        logic [efi_pkg::CW_W-1:0] m;
        m = '0;
        if (ptr < efi_pkg::PTR_LIMIT)
            m[ptr] = 1'b1;
        return m;
    endfunction

    always_comb
    begin
        cw_out = cw_in;
        if (flip_en)
            cw_out = cw_in ^ flip_mask(ptr_a) ^ flip_mask(ptr_b);
    end
endmodule
`default_nettype wire

// ===== logic/efi_secded.sv
// hamming sec parity, syndrome and double error decision for the codeword
`timescale 1ns/10ps
`default_nettype none
module efi_secded
(
    input  wire logic [efi_pkg::CW_W-1:0]  cw,
    output logic      [efi_pkg::SEC_W-1:0] calc_par,
    output logic      [efi_pkg::SEC_W-1:0] syndrome,
    output logic                           single_err,
    output logic                           double_err
);
    // data bit i is covered by parity j when bit j of (i+1) is set
    function automatic logic [7:0] sec_tree(input logic [efi_pkg::DATA_W-1:0] d);
        logic [7:0] p;
        logic [8:0] idx;
        p = '0;
        for (int i = 0; i < efi_pkg::DATA_W; i++)
        begin
            idx = 9'(i + 1);
            for (int j = 0; j < 8; j++)
                if (idx[j])
                    p[j] = p[j] ^ d[i];
        end
        return p;
    endfunction

    logic overall;

    always_comb
    begin
        calc_par   = sec_tree(cw[efi_pkg::DATA_W-1:0]);
        syndrome   = calc_par ^ cw[efi_pkg::DATA_W +: efi_pkg::SEC_W];
        overall    = ^cw;
        single_err = (syndrome != 8'h00) && overall;
        double_err = (syndrome != 8'h00) && !overall;
    end
endmodule
`default_nettype wire

// ===== logic/efi_top.sv
// apb register block for ecc fault injection and latched correction status
`timescale 1ns/10ps
`default_nettype none
module efi_top
(
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [efi_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      mem_rd_valid,
    input  wire logic [31:0]               mem_rd_addr,
    input  wire logic [efi_pkg::CW_W-1:0]  mem_rd_codeword,
    output logic      [efi_pkg::CW_W-1:0]  mem_rd_checked,
    output logic                           mem_single_err,
    output logic                           mem_double_err,
    output logic                           irq
);
    // configuration written by software
    logic        enable_r,   enable_nxt;
    logic [7:0]  ptr_a_r,    ptr_a_nxt;
    logic [7:0]  ptr_b_r,    ptr_b_nxt;
    logic [15:0] addr_lo_r,  addr_lo_nxt;
    logic [15:0] addr_hi_r,  addr_hi_nxt;

    // status latched from memory reads, and the interrupt mask written by software
    logic [7:0]  calc_r,     calc_nxt;
    logic [7:0]  stored_r,   stored_nxt;
    logic        ded_flag_r, ded_flag_nxt;
    logic        ded_par_r,  ded_par_nxt;
    logic [7:0]  synd_r,     synd_nxt;
    logic [efi_pkg::IRQ_W-1:0] ist_r, ist_nxt;
    logic [efi_pkg::IRQ_W-1:0] imask_r, imask_nxt;

    // bus answer and memory side outputs
    logic [31:0] prdata_r,   prdata_nxt;
    logic        pready_r,   pready_nxt;
    logic        pslverr_r,  pslverr_nxt;
    logic        irq_r,      irq_nxt;
    logic [efi_pkg::CW_W-1:0] checked_r, checked_nxt;
    logic        serr_r,     serr_nxt;
    logic        derr_r,     derr_nxt;

    logic                     match;
    logic [efi_pkg::CW_W-1:0] cw_flipped;
    logic [7:0]               calc_par;
    logic [7:0]               syndrome;
    logic                     single_err;
    logic                     double_err;
    logic                     setup;
    logic                     wr_en;
    logic                     mapped;
    logic [efi_pkg::IRQ_W-1:0] events;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        logic [15:0] v;
        v = old;
        if (st[0])
            v[7:0] = wd[7:0];
        if (st[1])
            v[15:8] = wd[15:8];
        return v;
    endfunction

    function automatic logic is_mapped(input logic [efi_pkg::ADDR_W-1:0] a);
        return a == efi_pkg::OFF_CFG_LOW  || a == efi_pkg::OFF_CFG_HIGH
            || a == efi_pkg::OFF_ADDR_LOW || a == efi_pkg::OFF_ADDR_HIGH
            || a == efi_pkg::OFF_STAT_LOW || a == efi_pkg::OFF_STAT_HIGH
            || a == efi_pkg::OFF_IRQ_STAT || a == efi_pkg::OFF_IRQ_MASK;
    endfunction

    // injection only on an enabled read at the compare address
    assign match = mem_rd_valid && (mem_rd_addr == {addr_hi_r, addr_lo_r});

    efi_bit_flip u_flip
    (
        .cw_in   (mem_rd_codeword),
        .flip_en (match && enable_r),
        .ptr_a   (ptr_a_r),
        .ptr_b   (ptr_b_r),
        .cw_out  (cw_flipped)
    );

    // checking sees the codeword after injection, so status shows the fault
    efi_secded u_secded
    (
        .cw         (cw_flipped),
        .calc_par   (calc_par),
        .syndrome   (syndrome),
        .single_err (single_err),
        .double_err (double_err)
    );

    // error pulses count only while a read is presented
    function automatic logic read_flag(input logic valid,
                                       input logic err);
        return valid && err;
    endfunction

    always_comb
    begin
        setup  = psel && !penable;
        wr_en  = psel && penable && pready_r && pwrite;
        mapped = is_mapped(paddr);
        events = '0;
        events[efi_pkg::IRQ_MATCH_BIT]  = match;
        events[efi_pkg::IRQ_SINGLE_BIT] = read_flag(mem_rd_valid, single_err);
        events[efi_pkg::IRQ_DOUBLE_BIT] = read_flag(mem_rd_valid, double_err);
    end

    // next state of configuration and status
    always_comb
    begin
        enable_nxt   = enable_r;
        ptr_a_nxt    = ptr_a_r;
        ptr_b_nxt    = ptr_b_r;
        addr_lo_nxt  = addr_lo_r;
        addr_hi_nxt  = addr_hi_r;
        calc_nxt     = calc_r;
        stored_nxt   = stored_r;
        ded_flag_nxt = ded_flag_r;
        ded_par_nxt  = ded_par_r;
        synd_nxt     = synd_r;
        imask_nxt    = imask_r;
        ist_nxt      = ist_r;
        // software writes; a read in the same cycle overrides status
        if (wr_en)
        begin
            case (paddr)
                efi_pkg::OFF_CFG_LOW:
                    if (pstrb[0])
                        enable_nxt = pwdata[efi_pkg::ENABLE_BIT];
                efi_pkg::OFF_CFG_HIGH:
                begin
                    if (pstrb[0])
                        ptr_a_nxt = pwdata[efi_pkg::PTR_A_LSB +: 8];
                    if (pstrb[1])
                        ptr_b_nxt = pwdata[efi_pkg::PTR_B_LSB +: 8];
                end
                efi_pkg::OFF_ADDR_LOW:
                    addr_lo_nxt = merge16(addr_lo_r, pwdata, pstrb);
                efi_pkg::OFF_ADDR_HIGH:
                    addr_hi_nxt = merge16(addr_hi_r, pwdata, pstrb);
                efi_pkg::OFF_STAT_LOW:
                begin
                    if (pstrb[0])
                        stored_nxt = pwdata[efi_pkg::STORED_LSB +: 8];
                    if (pstrb[1])
                        calc_nxt = pwdata[efi_pkg::CALC_LSB +: 8];
                end
                efi_pkg::OFF_STAT_HIGH:
                begin
                    if (pstrb[0])
                        synd_nxt = pwdata[efi_pkg::SYND_LSB +: 8];
                    if (pstrb[1])
                    begin
                        ded_par_nxt  = pwdata[efi_pkg::DED_PAR_BIT];
                        ded_flag_nxt = pwdata[efi_pkg::DED_FLAG_BIT];
                    end
                end
                efi_pkg::OFF_IRQ_STAT:
                    if (pstrb[0])
                        ist_nxt = ist_r & ~pwdata[efi_pkg::IRQ_W-1:0];
                efi_pkg::OFF_IRQ_MASK:
                    if (pstrb[0])
                        imask_nxt = pwdata[efi_pkg::IRQ_W-1:0];
                default:
                    ;
            endcase
        end
        // computed parity follows every read, the rest only a match
        if (mem_rd_valid)
            calc_nxt = calc_par;
        if (match)
        begin
            stored_nxt   = cw_flipped[efi_pkg::DATA_W +: efi_pkg::SEC_W];
            ded_flag_nxt = double_err;
            ded_par_nxt  = cw_flipped[efi_pkg::DED_POS];
            synd_nxt     = syndrome;
        end
        // a new event wins over a clear in the same cycle
        ist_nxt = ist_nxt | events;
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    // zero wait states: a setup cycle is answered at the next edge
    always_comb
    begin
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        if (setup)
        begin
            pready_nxt  = 1'b1;
            pslverr_nxt = !mapped;
            prdata_nxt  = 32'h0000_0000;
            if (!pwrite)
            begin
                case (paddr)
                    efi_pkg::OFF_CFG_LOW:
                        prdata_nxt[efi_pkg::ENABLE_BIT] = enable_r;
                    efi_pkg::OFF_CFG_HIGH:
                        prdata_nxt[15:0] = {ptr_b_r, ptr_a_r};
                    efi_pkg::OFF_ADDR_LOW:
                        prdata_nxt[15:0] = addr_lo_r;
                    efi_pkg::OFF_ADDR_HIGH:
                        prdata_nxt[15:0] = addr_hi_r;
                    efi_pkg::OFF_STAT_LOW:
                        prdata_nxt[15:0] = {calc_r, stored_r};
                    efi_pkg::OFF_STAT_HIGH:
                        prdata_nxt[9:0] = {ded_flag_r, ded_par_r, synd_r};
                    efi_pkg::OFF_IRQ_STAT:
                        prdata_nxt[efi_pkg::IRQ_W-1:0] = ist_r;
                    efi_pkg::OFF_IRQ_MASK:
                        prdata_nxt[efi_pkg::IRQ_W-1:0] = imask_r;
                    default:
                        prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
        checked_nxt = cw_flipped;
        serr_nxt    = read_flag(mem_rd_valid, single_err);
        derr_nxt    = read_flag(mem_rd_valid, double_err);
    end

    // all state clears together on reset
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            enable_r   <= 1'b0;
            ptr_a_r    <= 8'h00;
            ptr_b_r    <= 8'h00;
            addr_lo_r  <= efi_pkg::REG_RESET;
            addr_hi_r  <= efi_pkg::REG_RESET;
            calc_r     <= 8'h00;
            stored_r   <= 8'h00;
            ded_flag_r <= 1'b0;
            ded_par_r  <= 1'b0;
            synd_r     <= 8'h00;
            ist_r      <= '0;
            imask_r    <= '0;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            irq_r      <= 1'b0;
            checked_r  <= '0;
            serr_r     <= 1'b0;
            derr_r     <= 1'b0;
        end
        else
        begin
            enable_r   <= enable_nxt;
            ptr_a_r    <= ptr_a_nxt;
            ptr_b_r    <= ptr_b_nxt;
            addr_lo_r  <= addr_lo_nxt;
            addr_hi_r  <= addr_hi_nxt;
            calc_r     <= calc_nxt;
            stored_r   <= stored_nxt;
            ded_flag_r <= ded_flag_nxt;
            ded_par_r  <= ded_par_nxt;
            synd_r     <= synd_nxt;
            ist_r      <= ist_nxt;
            imask_r    <= imask_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            irq_r      <= irq_nxt;
            checked_r  <= checked_nxt;
            serr_r     <= serr_nxt;
            derr_r     <= derr_nxt;
        end
    end

    // every output is a plain register
    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign irq            = irq_r;
    assign mem_rd_checked = checked_r;
    assign mem_single_err = serr_r;
    assign mem_double_err = derr_r;
endmodule
`default_nettype wire

// ===== test/efi_top_properties.sv
// port-level assertions for the ecc fault injection block
`timescale 1ns/10ps
`default_nettype none
module efi_top_properties
(
    input wire logic                       sys_clk,
    input wire logic                       reset,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [efi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       mem_rd_valid,
    input wire logic [31:0]                mem_rd_addr,
    input wire logic [efi_pkg::CW_W-1:0]   mem_rd_codeword,
    input wire logic [efi_pkg::CW_W-1:0]   mem_rd_checked,
    input wire logic                       mem_single_err,
    input wire logic                       mem_double_err,
    input wire logic                       irq
);
    logic        en_r;
    logic [15:0] ptr_r;
    logic [31:0] cmp_r;
    logic        setup;
    logic        hit;
    assign setup = psel && !penable;
    assign hit   = mem_rd_valid && en_r && mem_rd_addr == cmp_r;
    // shadow of configuration written over the bus
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            en_r  <= 1'b0;
            ptr_r <= 16'h0000;
            cmp_r <= 32'h0000_0000;
        end
        else if (psel && penable && pready && pwrite)
        begin
            if (paddr == efi_pkg::OFF_CFG_LOW && pstrb[0])
                en_r <= pwdata[0];
            for (int b = 0; b < 2; b++)
                if (pstrb[b])
                begin
                    if (paddr == efi_pkg::OFF_CFG_HIGH)
                        ptr_r[8*b +: 8] <= pwdata[8*b +: 8];
                    if (paddr == efi_pkg::OFF_ADDR_LOW)
                        cmp_r[8*b +: 8] <= pwdata[8*b +: 8];
                    if (paddr == efi_pkg::OFF_ADDR_HIGH)
                        cmp_r[16+8*b +: 8] <= pwdata[8*b +: 8];
                end
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    chk_setup_answered: assert property (setup |=> pready ##1 !pready)
        else $error("access phase not answered in one cycle");
    chk_unmapped_err: assert property (setup && paddr > efi_pkg::OFF_IRQ_MASK
        |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
    chk_enable_read: assert property (setup && !pwrite
        && paddr == efi_pkg::OFF_CFG_LOW |=> prdata == {31'h0000_0000, en_r})
        else $error("enable register readback wrong");
    chk_pointer_read: assert property (setup && !pwrite
        && paddr == efi_pkg::OFF_CFG_HIGH |=> prdata == {16'h0000, ptr_r})
        else $error("pointer readback wrong");
    chk_address_read: assert property (setup && !pwrite
        && paddr == efi_pkg::OFF_ADDR_HIGH |=> prdata == {16'h0000, cmp_r[31:16]})
        else $error("compare address readback wrong");
    chk_stat_unused: assert property (setup && !pwrite
        && paddr == efi_pkg::OFF_STAT_HIGH |=> prdata[31:10] == 22'h000000)
        else $error("unused status bits not zero");
    chk_no_inject: assert property (mem_rd_valid && !hit
        |=> mem_rd_checked == $past(mem_rd_codeword)) else $error("codeword altered without hit");
    chk_far_pointers: assert property (hit && ptr_r[7:0] >= 8'h89
        && ptr_r[15:8] >= 8'h89 |=> mem_rd_checked == $past(mem_rd_codeword))
        else $error("out of range pointer flipped");
    chk_flip_one: assert property (hit && ptr_r[7:0] < 8'h89
        && ptr_r[15:8] >= 8'h89
        |=> (mem_rd_checked ^ $past(mem_rd_codeword)) == (137'h1 << ptr_r[7:0]))
        else $error("pointed bit not flipped");
    chk_flip_two: assert property (hit && ptr_r[7:0] < 8'h89
        && ptr_r[15:8] < 8'h89 |=> (mem_rd_checked ^ $past(mem_rd_codeword))
        == ((137'h1 << ptr_r[7:0]) ^ (137'h1 << ptr_r[15:8])))
        else $error("two pointed bits not flipped");
    chk_err_exclusive: assert property (!(mem_single_err && mem_double_err))
        else $error("single and double error together");
    chk_err_idle: assert property (!mem_rd_valid
        |=> !mem_single_err && !mem_double_err) else $error("error pulse without a read");
    chk_reset_quiet: assert property ($past(reset)
        |-> !pready && !irq && !mem_double_err) else $error("outputs active right after reset");
endmodule
bind efi_top efi_top_properties u_efi_top_properties
(
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr),
    .mem_rd_valid(mem_rd_valid), .mem_rd_addr(mem_rd_addr),
    .mem_rd_codeword(mem_rd_codeword), .mem_rd_checked(mem_rd_checked),
    .mem_single_err(mem_single_err), .mem_double_err(mem_double_err), .irq(irq)
);
`default_nettype wire

// ===== test/test_efi_top.sv
// self-checking bench: registers, injection, latched status and interrupt
`timescale 1ns/10ps
`default_nettype none
module test_efi_top;
    logic         sys_clk, reset, psel, penable, pwrite, mem_rd_valid;
    logic         pready, pslverr, mem_single_err, mem_double_err, irq;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, mem_rd_addr;
    logic [3:0]   pstrb;
    logic [136:0] mem_rd_codeword, mem_rd_checked, c;
    logic [15:0]  sl, sh;
    logic [2:0]   irq_st;
    logic [15:0]  ptab [4] = '{16'h8905, 16'h880a, 16'hff89, 16'h8100};
    int           n_fail, check_count;
    efi_top u_efi_top (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_rd_valid(mem_rd_valid),
        .mem_rd_addr(mem_rd_addr), .mem_rd_codeword(mem_rd_codeword),
        .mem_rd_checked(mem_rd_checked), .mem_single_err(mem_single_err),
        .mem_double_err(mem_double_err), .irq(irq));
    task automatic conclude;
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [136:0] g, input logic [136:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] hp(input logic [127:0] d);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 128; i++)
            for (int j = 0; j < 8; j++)
                if (((i + 1) >> j) & 1)
                    p[j] = p[j] ^ d[i];
        return p;
    endfunction
    function automatic logic [136:0] mk(input logic [127:0] d);
        logic [136:0] w;
        w = {1'b0, hp(d), d};
        w[136] = ^w[135:0];
        return w;
    endfunction
    function automatic logic [136:0] flip(input logic [136:0] w, input logic [15:0] p);
        for (int i = 0; i < 2; i++)
            if (p[8*i +: 8] < 8'h89)
                w[p[8*i +: 8]] = ~w[p[8*i +: 8]];
        return w;
    endfunction
    // caller enters just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [31:0] q, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        logic        er;
        xfer(1'b1, a, d, q, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] q;
        logic        er;
        xfer(1'b0, a, 16'h0000, q, er);
        chk({er, q}, {a > efi_pkg::OFF_IRQ_MASK, 16'h0000, e});
    endtask
    task automatic all_clear;
        for (int k = 0; k < 9; k++)
            rd(8'(4 * k), 16'h0000);
    endtask
    task automatic irq_is(input logic e);
        @(negedge sys_clk);
        chk(irq, e);
        @(posedge sys_clk);
    endtask
    // present one read; f is the codeword expected after injection
    task automatic run(input logic [31:0] a, input logic [136:0] w, input logic [136:0] f,
                       input logic m);
        logic [7:0] cp;
        logic [7:0] sy;
        logic       sg;
        logic       db;
        cp = hp(f[127:0]);
        sy = cp ^ f[135:128];
        sg = (sy != 8'h00) && (^f);
        db = (sy != 8'h00) && !(^f);
        mem_rd_valid <= 1'b1;
        mem_rd_addr <= a;
        mem_rd_codeword <= w;
        @(posedge sys_clk);
        mem_rd_valid <= 1'b0;
        mem_rd_codeword <= ~w;
        @(negedge sys_clk);
        chk(mem_rd_checked, f);
        chk({mem_single_err, mem_double_err}, {sg, db});
        @(posedge sys_clk);
        sl[15:8] = cp;
        if (m)
        begin
            sl[7:0] = f[135:128];
            sh = {6'h00, db, f[136], sy};
        end
        irq_st = irq_st | {db, sg, m};
        rd(efi_pkg::OFF_STAT_LOW, sl);
        rd(efi_pkg::OFF_STAT_HIGH, sh);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        conclude();
    end
    initial
    begin
        {reset, psel, penable, pwrite, mem_rd_valid} = 5'b10000;
        {paddr, pwdata, mem_rd_addr, mem_rd_codeword} = '0;
        pstrb = 4'hf;
        {n_fail, check_count} = '0;
        {sl, sh, irq_st} = '0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        all_clear();
        wr(efi_pkg::OFF_CFG_LOW, 16'hffff);
        rd(efi_pkg::OFF_CFG_LOW, 16'h0001);
        wr(efi_pkg::OFF_STAT_HIGH, 16'hffff);
        rd(efi_pkg::OFF_STAT_HIGH, 16'h03ff);
        wr(efi_pkg::OFF_STAT_HIGH, 16'h0000);
        wr(efi_pkg::OFF_ADDR_LOW, 16'h5678);
        wr(efi_pkg::OFF_ADDR_HIGH, 16'h1234);
        rd(efi_pkg::OFF_ADDR_LOW, 16'h5678);
        rd(efi_pkg::OFF_ADDR_HIGH, 16'h1234);
        for (int k = 0; k < 4; k++)
        begin
            c = mk({4{32'hc3a5_0f1e ^ 32'(k)}});
            wr(efi_pkg::OFF_CFG_HIGH, ptab[k]);
            rd(efi_pkg::OFF_CFG_HIGH, ptab[k]);
            run(32'h1234_5678, c, flip(c, ptab[k]), 1'b1);
        end
        run(32'h1234_5679, c, c, 1'b0);
        wr(efi_pkg::OFF_CFG_LOW, 16'h0000);
        run(32'h1234_5678, c, c, 1'b1);
        rd(efi_pkg::OFF_IRQ_STAT, {13'h0000, irq_st});
        irq_is(1'b0);
        wr(efi_pkg::OFF_IRQ_MASK, 16'h0007);
        rd(efi_pkg::OFF_IRQ_MASK, 16'h0007);
        irq_is(1'b1);
        wr(efi_pkg::OFF_IRQ_STAT, {13'h0000, irq_st});
        irq_st = 3'b000;
        rd(efi_pkg::OFF_IRQ_STAT, 16'h0000);
        irq_is(1'b0);
        wr(efi_pkg::OFF_IRQ_MASK, 16'h0004);
        c[7] = ~c[7];
        run(32'h0000_0000, c, c, 1'b0);
        irq_is(1'b0);
        wr(efi_pkg::OFF_IRQ_MASK, 16'h0002);
        irq_is(1'b1);
        wr(efi_pkg::OFF_IRQ_STAT, 16'h0002);
        irq_is(1'b0);
        // byte strobes: only the upper pointer lane is written
        pstrb <= 4'h2;
        wr(efi_pkg::OFF_CFG_HIGH, 16'h3377);
        pstrb <= 4'hf;
        rd(efi_pkg::OFF_CFG_HIGH, 16'h3300);
        // second reset in mid-run must clear everything again
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        all_clear();
        irq_is(1'b0);
        conclude();
    end
endmodule
`default_nettype wire
